//--- core/bridge_regs_pkg.sv
// bridge_regs_pkg: offsets, field positions and reset values of the bridge command and status registers
// assumes a 16-bit config word port with byte enables, offsets in bytes
package bridge_regs_pkg;
  localparam logic [7:0] CMD_OFFSET = 8'h04;
  localparam logic [7:0] STS_OFFSET = 8'h06;
  localparam logic [15:0] CMD_RESET = 16'h0006;
  localparam logic [15:0] STS_RESET = 16'h0090;
  localparam int SERR_EN_BIT = 8;
  localparam int SSE_BIT = 14;
  localparam int RMA_BIT = 13;
  localparam int RTA_BIT = 12;
  // read-only constant part of the command word: memory and master enables set, rest zero
  localparam logic [15:0] CMD_CONST = 16'h0006;
  // read-only constant part of status: fast back-to-back capable and capability list
  localparam logic [15:0] STS_CONST = 16'h0090;
endpackage

//--- core/sticky_bit.sv
// sticky_bit: one hardware-set, write-one-to-clear status flag
// assumes set and clear arrive on clk_in
`timescale 1ns/1ns
`default_nettype none
module sticky_bit (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic set_in,
  input wire logic clr_in,
  output logic flag_out
);
  // set wins over a clear in the same cycle so no event is lost
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      flag_out <= 1'b0;
    end else if (set_in) begin
      flag_out <= 1'b1;
    end else if (clr_in) begin
      flag_out <= 1'b0;
    end
  end
endmodule // sticky_bit
`default_nettype wire

//--- core/serr_gate.sv
// serr_gate: forms one system-error message request per rising error event
// assumes error lines are synchronous to clk_in
`timescale 1ns/1ns
`default_nettype none
module serr_gate (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic enable_in,
  input wire logic err_in,
  output logic send_out
);
  logic err_d_r;
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      err_d_r <= 1'b0;
    end else begin
      err_d_r <= err_in;
    end
  end
  assign send_out = enable_in & err_in & ~err_d_r;
endmodule // serr_gate
`default_nettype wire

//--- core/host_bridge_command_status_regs.sv
// host_bridge_command_status_regs: command and status words of the host bridge function
// assumes a synchronous config port and error lines from logic on clk_in
`timescale 1ns/1ns
`default_nettype none
module host_bridge_command_status_regs
  import bridge_regs_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic cfg_wr_in,
  input wire logic cfg_rd_in,
  input wire logic [7:0] cfg_addr_in,
  input wire logic [1:0] cfg_be_in,
  input wire logic [15:0] cfg_wdata_in,
  output logic [15:0] cfg_rdata_out,
  input wire logic [7:0] error_command_in,
  input wire logic [7:0] error_events_in,
  input wire logic master_abort_in,
  input wire logic target_abort_in,
  input wire logic fn1_serr_enable_in,
  input wire logic fn1_error_in,
  output logic hub_link_serr_msg_out,
  output logic memory_access_enable_out,
  output logic bus_master_enable_out
);
  logic serr_en_r;
  logic cmd_hit;
  logic sts_hit;
  logic fn0_any;
  logic fn0_send;
  logic fn1_send;
  logic sse_clr;
  logic rma_clr;
  logic rta_clr;
  logic sse_flag;
  logic rma_flag;
  logic rta_flag;
  logic [15:0] cmd_word;
  logic [15:0] sts_word;

  assign cmd_hit = (cfg_addr_in == CMD_OFFSET);
  assign sts_hit = (cfg_addr_in == STS_OFFSET);

  // only bit 8 of the high byte stores
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      serr_en_r <= CMD_RESET[SERR_EN_BIT];
    end else if (cfg_wr_in && cmd_hit && cfg_be_in[1]) begin
      serr_en_r <= cfg_wdata_in[SERR_EN_BIT];
    end
  end

  assign fn0_any = |(error_command_in & error_events_in);
  serr_gate fn0_gate (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .enable_in(serr_en_r),
    .err_in(fn0_any),
    .send_out(fn0_send)
  );
  serr_gate fn1_gate (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .enable_in(fn1_serr_enable_in),
    .err_in(fn1_error_in),
    .send_out(fn1_send)
  );

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      hub_link_serr_msg_out <= 1'b0;
    end else begin
      hub_link_serr_msg_out <= fn0_send | fn1_send;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      memory_access_enable_out <= 1'b0;
      bus_master_enable_out <= 1'b0;
    end else begin
      memory_access_enable_out <= CMD_CONST[1];
      bus_master_enable_out <= CMD_CONST[2];
    end
  end

  assign sse_clr = cfg_wr_in & sts_hit & cfg_be_in[1] & cfg_wdata_in[SSE_BIT];
  assign rma_clr = cfg_wr_in & sts_hit & cfg_be_in[1] & cfg_wdata_in[RMA_BIT];
  assign rta_clr = cfg_wr_in & sts_hit & cfg_be_in[1] & cfg_wdata_in[RTA_BIT];

  sticky_bit sse_bit (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .set_in(fn0_send),
    .clr_in(sse_clr),
    .flag_out(sse_flag)
  );
  sticky_bit rma_bit (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .set_in(master_abort_in),
    .clr_in(rma_clr),
    .flag_out(rma_flag)
  );
  sticky_bit rta_bit (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .set_in(target_abort_in),
    .clr_in(rta_clr),
    .flag_out(rta_flag)
  );

  always_comb begin
    cmd_word = CMD_CONST;
    cmd_word[SERR_EN_BIT] = serr_en_r;
    sts_word = STS_CONST;
    sts_word[SSE_BIT] = sse_flag;
    sts_word[RMA_BIT] = rma_flag;
    sts_word[RTA_BIT] = rta_flag;
  end

  // read data registered; unmapped offsets return zero
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      cfg_rdata_out <= 16'h0000;
    end else if (cfg_rd_in && cmd_hit) begin
      cfg_rdata_out <= cmd_word;
    end else if (cfg_rd_in && sts_hit) begin
      cfg_rdata_out <= sts_word;
    end else if (cfg_rd_in) begin
      cfg_rdata_out <= 16'h0000;
    end
  end

  no_msg_off_a: assert property (@(posedge clk_in) disable iff (rst_in)
    (!serr_en_r && !fn1_send) |=> !hub_link_serr_msg_out)
    else $error("message sent with enable clear");

  sse_set_a: assert property (@(posedge clk_in) disable iff (rst_in)
    fn0_send |=> sse_flag)
    else $error("system error flag not set");

  msg_follow_a: assert property (@(posedge clk_in) disable iff (rst_in)
    (fn0_send || fn1_send) |=> hub_link_serr_msg_out)
    else $error("message not sent");

  enable_write_a: assert property (@(posedge clk_in) disable iff (rst_in)
    (cfg_wr_in && cmd_hit && cfg_be_in[1]) |=> serr_en_r == $past(cfg_wdata_in[SERR_EN_BIT]))
    else $error("enable not written");

  cmd_read_a: assert property (@(posedge clk_in) disable iff (rst_in)
    (cfg_rd_in && cmd_hit) |=> (cfg_rdata_out & 16'hFEFF) == 16'h0006)
    else $error("command fixed bits wrong");

  sts_read_a: assert property (@(posedge clk_in) disable iff (rst_in)
    (cfg_rd_in && sts_hit) |=> (cfg_rdata_out & 16'h8FFF) == 16'h0090)
    else $error("status fixed bits wrong");

  sse_clear_a: assert property (@(posedge clk_in) disable iff (rst_in)
    (sse_clr && !fn0_send) |=> !sse_flag)
    else $error("flag not cleared");

  fixed_enables_a: assert property (@(posedge clk_in) disable iff (rst_in)
    !$past(rst_in) |-> (memory_access_enable_out && bus_master_enable_out))
    else $error("fixed enables low");

  cmd_reserved_a: assert property (@(posedge clk_in) disable iff (rst_in)
    (cfg_rd_in && cmd_hit) |=> cfg_rdata_out[15:10] == 6'h00)
    else $error("command reserved bits set");

  fast_back_to_back_enable_zero_a: assert property (@(posedge clk_in) disable iff (rst_in)
    (cfg_rd_in && cmd_hit) |=> !cfg_rdata_out[9])
    else $error("back-to-back bit set");

  stepping_zero_a: assert property (@(posedge clk_in) disable iff (rst_in)
    (cfg_rd_in && cmd_hit) |=> !cfg_rdata_out[7])
    else $error("stepping bit set");

  parity_zero_a: assert property (@(posedge clk_in) disable iff (rst_in)
    (cfg_rd_in && cmd_hit) |=> !cfg_rdata_out[6])
    else $error("parity bit set");

  snoop_zero_a: assert property (@(posedge clk_in) disable iff (rst_in)
    (cfg_rd_in && cmd_hit) |=> !cfg_rdata_out[5])
    else $error("snoop bit set");

  invalidate_zero_a: assert property (@(posedge clk_in) disable iff (rst_in)
    (cfg_rd_in && cmd_hit) |=> !cfg_rdata_out[4])
    else $error("invalidate bit set");

  special_zero_a: assert property (@(posedge clk_in) disable iff (rst_in)
    (cfg_rd_in && cmd_hit) |=> !cfg_rdata_out[3])
    else $error("special cycle bit set");

  master_read_a: assert property (@(posedge clk_in) disable iff (rst_in)
    (cfg_rd_in && cmd_hit) |=> cfg_rdata_out[2])
    else $error("master bit clear");

  memory_read_a: assert property (@(posedge clk_in) disable iff (rst_in)
    (cfg_rd_in && cmd_hit) |=> cfg_rdata_out[1])
    else $error("memory bit clear");

  io_zero_a: assert property (@(posedge clk_in) disable iff (rst_in)
    (cfg_rd_in && cmd_hit) |=> !cfg_rdata_out[0])
    else $error("io bit set");

  enable_read_a: assert property (@(posedge clk_in) disable iff (rst_in)
    (cfg_rd_in && cmd_hit) |=> cfg_rdata_out[SERR_EN_BIT] == $past(serr_en_r))
    else $error("enable read wrong");

  enable_hold_a: assert property (@(posedge clk_in) disable iff (rst_in)
    !(cfg_wr_in && cmd_hit && cfg_be_in[1]) |=> $stable(serr_en_r))
    else $error("enable changed without write");

  fn0_gated_a: assert property (@(posedge clk_in) disable iff (rst_in)
    fn0_send |-> serr_en_r)
    else $error("function 0 send while disabled");

  fn0_cause_a: assert property (@(posedge clk_in) disable iff (rst_in)
    fn0_send |-> fn0_any)
    else $error("function 0 send without error");

  fn1_gated_a: assert property (@(posedge clk_in) disable iff (rst_in)
    fn1_send |-> fn1_serr_enable_in)
    else $error("function 1 send while disabled");

  msg_cause_a: assert property (@(posedge clk_in) disable iff (rst_in)
    hub_link_serr_msg_out |-> ($past(fn0_send) || $past(fn1_send)))
    else $error("message without send");

  sse_cause_a: assert property (@(posedge clk_in) disable iff (rst_in)
    $rose(sse_flag) |-> $past(fn0_send))
    else $error("flag set without send");

  sse_read_a: assert property (@(posedge clk_in) disable iff (rst_in)
    (cfg_rd_in && sts_hit) |=> cfg_rdata_out[SSE_BIT] == $past(sse_flag))
    else $error("status bit 14 read wrong");

  rma_read_a: assert property (@(posedge clk_in) disable iff (rst_in)
    (cfg_rd_in && sts_hit) |=> cfg_rdata_out[RMA_BIT] == $past(rma_flag))
    else $error("status bit 13 read wrong");

  rta_read_a: assert property (@(posedge clk_in) disable iff (rst_in)
    (cfg_rd_in && sts_hit) |=> cfg_rdata_out[RTA_BIT] == $past(rta_flag))
    else $error("status bit 12 read wrong");

  rma_set_a: assert property (@(posedge clk_in) disable iff (rst_in)
    master_abort_in |=> rma_flag)
    else $error("master abort flag not set");

  rta_set_a: assert property (@(posedge clk_in) disable iff (rst_in)
    target_abort_in |=> rta_flag)
    else $error("target abort flag not set");

  rma_clear_a: assert property (@(posedge clk_in) disable iff (rst_in)
    (rma_clr && !master_abort_in) |=> !rma_flag)
    else $error("master abort flag not cleared");

  rta_clear_a: assert property (@(posedge clk_in) disable iff (rst_in)
    (rta_clr && !target_abort_in) |=> !rta_flag)
    else $error("target abort flag not cleared");

  unmapped_read_a: assert property (@(posedge clk_in) disable iff (rst_in)
    (cfg_rd_in && !cmd_hit && !sts_hit) |=> cfg_rdata_out == 16'h0000)
    else $error("unmapped read not zero");

  rdata_hold_a: assert property (@(posedge clk_in) disable iff (rst_in)
    !cfg_rd_in |=> $stable(cfg_rdata_out))
    else $error("read data changed without read");

  sse_hold_a: assert property (@(posedge clk_in) disable iff (rst_in)
    (!fn0_send && !sse_clr) |=> $stable(sse_flag))
    else $error("flag changed without cause");

  sse_fn1_a: assert property (@(posedge clk_in) disable iff (rst_in)
    (!fn0_send && !sse_flag) |=> !sse_flag)
    else $error("flag set by other function");
endmodule // host_bridge_command_status_regs
`default_nettype wire

//--- dv/hub_link_sink.sv
// hub_link_sink: far end of the hub link, counts system-error messages
// assumes each message is a one-cycle pulse on clk_in
`timescale 1ns/1ns
`default_nettype none
module hub_link_sink (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic msg_in,
  output var int count_out
);
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      count_out <= 0;
    end else if (msg_in === 1'b1) begin
      count_out <= count_out + 1;
    end
  end
endmodule // hub_link_sink
`default_nettype wire

//--- dv/tb_top.sv
// tb_top: self-checking bench for the bridge command and status words
// assumes one clock; reads are compared by a monitor off a queue
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin n_errors++; \
  $display("unexpected %s exp %h got %h", nm, e, g); end end
module tb_top;
  import bridge_regs_pkg::*;
  logic clk_in = 0, rst_in = 1, cfg_wr_in = 0, cfg_rd_in = 0, rd_seen = 0;
  logic [7:0] cfg_addr_in = 0, error_command_in = 0, error_events_in = 0;
  logic [1:0] cfg_be_in = 0;
  logic [15:0] cfg_wdata_in = 0, cfg_rdata_out;
  logic master_abort_in = 0, target_abort_in = 0, fn1_serr_enable_in = 0, fn1_error_in = 0;
  logic hub_link_serr_msg_out, memory_access_enable_out, bus_master_enable_out;
  logic [15:0] exp_q[$];
  int n_errors = 0, n_tests = 0, n_msg, cycles = 0, seed;
  host_bridge_command_status_regs i_dut (.clk_in(clk_in), .rst_in(rst_in), .cfg_wr_in(cfg_wr_in),
    .cfg_rd_in(cfg_rd_in), .cfg_addr_in(cfg_addr_in), .cfg_be_in(cfg_be_in), .cfg_wdata_in(cfg_wdata_in),
    .cfg_rdata_out(cfg_rdata_out), .error_command_in(error_command_in), .error_events_in(error_events_in),
    .master_abort_in(master_abort_in), .target_abort_in(target_abort_in),
    .fn1_serr_enable_in(fn1_serr_enable_in), .fn1_error_in(fn1_error_in),
    .hub_link_serr_msg_out(hub_link_serr_msg_out), .memory_access_enable_out(memory_access_enable_out),
    .bus_master_enable_out(bus_master_enable_out));
  hub_link_sink i_sink (.clk_in(clk_in), .rst_in(rst_in), .msg_in(hub_link_serr_msg_out), .count_out(n_msg));
  initial begin
    forever #2 clk_in = ~clk_in;
  end
  // read data lands one cycle after the taking edge
  always @(posedge clk_in) begin
    if (rd_seen) `CHK("rdata", exp_q.pop_front(), cfg_rdata_out)
    rd_seen <= cfg_rd_in;
    cycles++;
    if (cycles == 2000) begin
      n_errors++;
      close_out();
    end
  end
  task automatic acc(input logic w, input logic [7:0] a, input logic [1:0] be, input logic [15:0] d);
    cfg_addr_in <= a;
    cfg_be_in <= be;
    cfg_wdata_in <= d;
    cfg_wr_in <= w;
    cfg_rd_in <= !w;
    @(posedge clk_in);
    cfg_wr_in <= 1'b0;
    cfg_rd_in <= 1'b0;
    @(posedge clk_in);
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    exp_q.push_back(e);
    acc(1'b0, a, 2'b00, 16'h0000);
  endtask
  // level held several cycles still yields one message
  task automatic ev(input logic [7:0] e, input logic f1);
    error_events_in <= e;
    fn1_error_in <= f1;
    repeat (4) @(posedge clk_in);
    error_events_in <= 8'h00;
    fn1_error_in <= 1'b0;
    repeat (2) @(posedge clk_in);
  endtask
  task automatic close_out();
    $display("counts: %0d tests %0d errors", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    seed = 32'h62BA;
    repeat (8) @(posedge clk_in);
    rst_in <= 1'b0;
    @(posedge clk_in);
    rd(CMD_OFFSET, 16'h0006);
    rd(STS_OFFSET, 16'h0090);
    `CHK("mae_bme", 2'b11, {memory_access_enable_out, bus_master_enable_out})
    $display("test reset done");
    acc(1'b1, CMD_OFFSET, 2'b11, 16'hFFFF);
    rd(CMD_OFFSET, 16'h0106);
    acc(1'b1, CMD_OFFSET, 2'b01, 16'($random(seed)));
    rd(CMD_OFFSET, 16'h0106);
    rd(8'h20, 16'h0000);
    $display("test command bits done");
    error_command_in <= 8'h01;
    ev(8'h01, 1'b0);
    `CHK("msg_on", 1, n_msg)
    master_abort_in <= 1'b1;
    target_abort_in <= 1'b1;
    @(posedge clk_in);
    master_abort_in <= 1'b0;
    target_abort_in <= 1'b0;
    rd(STS_OFFSET, 16'h7090);
    acc(1'b1, STS_OFFSET, 2'b10, 16'h7000);
    rd(STS_OFFSET, 16'h0090);
    $display("test enabled message done");
    acc(1'b1, CMD_OFFSET, 2'b10, 16'h0000);
    error_command_in <= 8'hFF;
    ev(8'($random(seed)) | 8'h01, 1'b0);
    `CHK("msg_off", 1, n_msg)
    fn1_serr_enable_in <= 1'b1;
    ev(8'h00, 1'b1);
    `CHK("msg_fn1", 2, n_msg)
    rd(STS_OFFSET, 16'h0090);
    $display("test disabled and second function done");
    acc(1'b1, CMD_OFFSET, 2'b10, 16'h0100);
    rst_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    rst_in <= 1'b0;
    @(posedge clk_in);
    rd(CMD_OFFSET, 16'h0006);
    rd(STS_OFFSET, 16'h0090);
    $display("test mid-run reset done");
    close_out();
  end
endmodule // tb_top
`default_nettype wire
